// File: inc/cidec_regs.svh
/*
  timing and field constants of the instruction decoder.
  assumes inclusion by bare name from the design file.
*/
`ifndef CIDEC_REGS_SVH
`define CIDEC_REGS_SVH
`define CIDEC_CYC_4 5'h04
`define CIDEC_CYC_5 5'h05
`define CIDEC_CYC_7 5'h07
`define CIDEC_CYC_10 5'h0A
`define CIDEC_CYC_11 5'h0B
`define CIDEC_CYC_13 5'h0D
`define CIDEC_REG_MEM 3'h6
`define CIDEC_REG_ACC 3'h7
`define CIDEC_OPC_STOP 8'h76
`define CIDEC_RST_VEC_SHIFT 3
`endif

// File: inc/cidec_pkg.sv
/*
  types of the instruction decoder.
  assumes nothing beyond the constants header.
*/
package cidec_pkg;
  typedef enum logic [3:0] {
    CIDEC_CLS_OTHER = 4'h0,
    CIDEC_CLS_COPY = 4'h1,
    CIDEC_CLS_STORE_M = 4'h2,
    CIDEC_CLS_LOAD_M = 4'h3,
    CIDEC_CLS_STOP = 4'h4,
    CIDEC_CLS_ALU = 4'h5,
    CIDEC_CLS_RET_COND = 4'h6,
    CIDEC_CLS_LOAD_PAIR = 4'h7,
    CIDEC_CLS_RESTART = 4'h8,
    CIDEC_CLS_IMM = 4'h9,
    CIDEC_CLS_PORT = 4'hA,
    CIDEC_CLS_BRANCH = 4'hB,
    CIDEC_CLS_DIRECT = 4'hC
  } cidec_cls_t;
  typedef enum logic [2:0] {
    CIDEC_ST_OPC = 3'b001,
    CIDEC_ST_BYTE2 = 3'b010,
    CIDEC_ST_BYTE3 = 3'b100
  } cidec_st_t;
endpackage : cidec_pkg

// File: verilog/cidec_decoder.sv
/*
  instruction assembler and opcode classifier.
  assumes program memory presents bytes in ascending address order with a valid strobe
  on the same clock; fetch_ready_out tells it to advance.
  the flag byte is read on the edge that takes the last byte of an instruction,
  so it must already describe the result that a condition tests.
*/
`timescale 1ns/1ps
`include "cidec_regs.svh"

module cidec_decoder (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [7:0] fetch_data_in,
  input wire logic fetch_valid_in,
  input wire logic [7:0] flags_in,
  output logic fetch_ready_out,
  output logic instr_valid_out,
  output logic [7:0] opcode_out,
  output logic [7:0] operand_lo_out,
  output logic [7:0] operand_hi_out,
  output logic [1:0] length_out,
  output cidec_pkg::cidec_cls_t op_class_out,
  output logic [2:0] dest_out,
  output logic [2:0] src_out,
  output logic [2:0] alu_sel_out,
  output logic alu_carry_in_out,
  output logic [2:0] cond_sel_out,
  output logic cond_met_out,
  output logic [1:0] pair_sel_out,
  output logic [15:0] restart_addr_out,
  output logic [4:0] cycles_out
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // number of bytes that follow the opcode
  function automatic logic [1:0] cidec_extra(input logic [7:0] op);
    logic [1:0] n;
    n = 2'h0;
    if (op[7:6] == 2'h0 && op[2:0] == 3'h6) n = 2'h1; // immediate load
    if (op[7:6] == 2'h3 && op[2:0] == 3'h6) n = 2'h1; // immediate alu
    if (op == 8'hDB || op == 8'hD3) n = 2'h1; // port in/out
    if (op[7:6] == 2'h0 && op[3:0] == 4'h1) n = 2'h2; // pair constant
    if (op[7:6] == 2'h0 && op[5] && op[2:0] == 3'h2) n = 2'h2; // direct access
    if (op[7:6] == 2'h3 && (op[2:0] == 3'h2 || op[2:0] == 3'h4)) n = 2'h2;
    if (op == 8'hC3 || op == 8'hCD) n = 2'h2; // jump, call
    return n;
  endfunction : cidec_extra

  // condition test of the flag byte: s z x ac x p x cy
  function automatic logic cidec_cond(input logic [2:0] c, input logic [7:0] f);
    logic r;
    r = 1'b0;
    unique case (c)
      3'h0: r = ~f[6]; // not zero
      3'h1: r = f[6]; // zero
      3'h2: r = ~f[0];
      3'h3: r = f[0];
      3'h4: r = ~f[2]; // parity odd
      3'h5: r = f[2]; // parity even
      3'h6: r = ~f[7]; // positive
      3'h7: r = f[7]; // minus
    endcase
    return r;
  endfunction : cidec_cond

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    cidec_pkg::cidec_st_t st;
    logic [1:0] need;
    logic [7:0] opc;
    logic [7:0] lo;
    logic [7:0] hi;
    logic vld;
    logic [1:0] len;
    cidec_pkg::cidec_cls_t cls;
    logic [2:0] dst;
    logic [2:0] src;
    logic [2:0] alu;
    logic cyin;
    logic [2:0] csel;
    logic cmet;
    logic [1:0] pair;
    logic [15:0] rst;
    logic [4:0] cyc;
  } cidec_state_t;

  cidec_state_t state;
  cidec_state_t next_state;
  logic [7:0] byte_in; // bytes are unsigned 8-bit
  logic [7:0] op_now;

  // bus byte used as sampled: high level is one
  assign byte_in = fetch_data_in;
  assign fetch_ready_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // assembly and classification

  always_comb begin
    next_state = state;
    next_state.vld = 1'b0;
    op_now = state.opc;
    if (fetch_valid_in) begin
      unique case (state.st)
        cidec_pkg::CIDEC_ST_OPC: begin
          next_state.opc = byte_in;
          next_state.lo = 8'h00;
          next_state.hi = 8'h00;
          next_state.need = cidec_extra(byte_in);
          op_now = byte_in;
          if (cidec_extra(byte_in) == 2'h0) begin
            next_state.vld = 1'b1;
          end else begin
            next_state.st = cidec_pkg::CIDEC_ST_BYTE2;
          end
        end
        cidec_pkg::CIDEC_ST_BYTE2: begin
          next_state.lo = byte_in; // low byte or first operand
          if (state.need == 2'h1) begin
            next_state.vld = 1'b1;
            next_state.st = cidec_pkg::CIDEC_ST_OPC;
          end else begin
            next_state.st = cidec_pkg::CIDEC_ST_BYTE3;
          end
        end
        cidec_pkg::CIDEC_ST_BYTE3: begin
          next_state.hi = byte_in; // high byte or second operand
          next_state.vld = 1'b1;
          next_state.st = cidec_pkg::CIDEC_ST_OPC;
        end
        default: next_state.st = cidec_pkg::CIDEC_ST_OPC;
      endcase
    end
    // classify once the instruction completes
    if (next_state.vld) begin
      next_state.len = 2'(cidec_extra(op_now) + 2'h1);
      next_state.dst = op_now[5:3];
      next_state.src = op_now[2:0];
      next_state.alu = op_now[5:3];
      next_state.csel = op_now[5:3];
      next_state.pair = op_now[5:4];
      next_state.cyin = 1'b0;
      next_state.cmet = 1'b0;
      next_state.rst = 16'h0000;
      next_state.cls = cidec_pkg::CIDEC_CLS_OTHER;
      next_state.cyc = `CIDEC_CYC_4;
      if (op_now == `CIDEC_OPC_STOP) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_STOP;
        next_state.cyc = `CIDEC_CYC_7;
      end else if (op_now[7:6] == 2'h1 && op_now[5:3] == `CIDEC_REG_MEM) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_STORE_M;
        next_state.cyc = `CIDEC_CYC_7;
      end else if (op_now[7:6] == 2'h1 && op_now[2:0] == `CIDEC_REG_MEM) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_LOAD_M;
        next_state.cyc = `CIDEC_CYC_7;
      end else if (op_now[7:6] == 2'h1) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_COPY;
        next_state.cyc = `CIDEC_CYC_5;
      end else if (op_now[7:6] == 2'h2) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_ALU;
        next_state.cyin = (op_now[5:3] == 3'h1) && flags_in[0];
        next_state.cyc = (op_now[2:0] == `CIDEC_REG_MEM) ? `CIDEC_CYC_7 : `CIDEC_CYC_4;
      end else if (op_now[7:6] == 2'h3 && op_now[2:0] == 3'h0) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_RET_COND;
        next_state.cmet = cidec_cond(op_now[5:3], flags_in);
        next_state.cyc = next_state.cmet ? `CIDEC_CYC_11 : `CIDEC_CYC_5;
      end else if (op_now[7:6] == 2'h3 && op_now[2:0] == 3'h7) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_RESTART;
        next_state.rst = {10'h000, op_now[5:3], 3'h0};
        next_state.cyc = `CIDEC_CYC_11;
      end else if (op_now[7:6] == 2'h0 && op_now[3:0] == 4'h1) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_LOAD_PAIR;
        next_state.cyc = `CIDEC_CYC_10;
      end else if (op_now == 8'hDB || op_now == 8'hD3) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_PORT;
        next_state.cyc = `CIDEC_CYC_10;
      end else if (op_now[7:6] == 2'h0 && op_now[2:0] == 3'h6) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_IMM;
        next_state.cyc = (op_now[5:3] == `CIDEC_REG_MEM) ? `CIDEC_CYC_10 : `CIDEC_CYC_7;
      end else if (op_now[7:6] == 2'h3 && op_now[2:0] == 3'h6) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_IMM;
        next_state.cyc = `CIDEC_CYC_7;
      end else if (op_now[7:6] == 2'h0 && op_now[5:4] == 2'h3 && op_now[2:0] == 3'h2) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_DIRECT;
        next_state.cyc = `CIDEC_CYC_13;
      end else if (cidec_extra(op_now) == 2'h2) begin
        next_state.cls = cidec_pkg::CIDEC_CLS_BRANCH;
        next_state.cyc = `CIDEC_CYC_10;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= '{st: cidec_pkg::CIDEC_ST_OPC, cls: cidec_pkg::CIDEC_CLS_OTHER, default: '0};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign instr_valid_out = state.vld;
  assign opcode_out = state.opc;
  assign operand_lo_out = state.lo;
  assign operand_hi_out = state.hi;
  assign length_out = state.len;
  assign op_class_out = state.cls;
  assign dest_out = state.dst;
  assign src_out = state.src;
  assign alu_sel_out = state.alu;
  assign alu_carry_in_out = state.cyin;
  assign cond_sel_out = state.csel;
  assign cond_met_out = state.cmet;
  assign pair_sel_out = state.pair;
  assign restart_addr_out = state.rst;
  assign cycles_out = state.cyc;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // the output properties look at the registered outputs in the cycle of the completion pulse; the fetch ones check the cycle after

  AST_COPY_CYC: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_COPY |-> cycles_out == 5'h05)
    else $error("copy cycle count wrong");
  AST_STOP: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && opcode_out == 8'h76 |->
      op_class_out == cidec_pkg::CIDEC_CLS_STOP && cycles_out == 5'h07)
    else $error("stop decode wrong");
  AST_LOAD_M: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && opcode_out[7:6] == 2'h1 && opcode_out[2:0] == 3'h6
      && opcode_out != 8'h76 |-> op_class_out == cidec_pkg::CIDEC_CLS_LOAD_M)
    else $error("memory load decode wrong");
  AST_ALU_CYC: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && opcode_out[7:6] == 2'h2 && opcode_out[2:0] != 3'h6
      |-> cycles_out == 5'h04 && length_out == 2'h1)
    else $error("alu decode wrong");
  AST_RET_CYC: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_RET_COND
      |-> cycles_out == (cond_met_out ? 5'h0B : 5'h05))
    else $error("return cycles wrong");
  AST_PAIR: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_LOAD_PAIR
      |-> length_out == 2'h3 && cycles_out == 5'h0A)
    else $error("pair load wrong");
  AST_THREE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    fetch_valid_in && state.st == cidec_pkg::CIDEC_ST_BYTE3
      |=> instr_valid_out && operand_hi_out == $past(fetch_data_in))
    else $error("third byte not taken as high");
  AST_ONE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    fetch_valid_in && state.st == cidec_pkg::CIDEC_ST_OPC && fetch_data_in[7:6] == 2'h1
      |=> instr_valid_out && length_out == 2'h1)
    else $error("single byte opcode waited");
  AST_RST: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_RESTART
      |-> restart_addr_out == {10'h000, opcode_out[5:3], 3'h0} && cycles_out == 5'h0B)
    else $error("restart wrong");
  // carry reaches the adder only for the add-with-carry code
  AST_CARRY: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out |-> alu_carry_in_out == (op_class_out == cidec_pkg::CIDEC_CLS_ALU
      && alu_sel_out == 3'h1 && $past(flags_in[0])))
    else $error("carry select wrong");
  // each condition pair tests one flag; the low code bit picks its sense
  AST_COND_Z: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_RET_COND
      && cond_sel_out[2:1] == 2'h0 |-> cond_met_out == (cond_sel_out[0] == $past(flags_in[6])))
    else $error("zero condition wrong");
  AST_COND_P: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_RET_COND
      && cond_sel_out[2:1] == 2'h2 |-> cond_met_out == (cond_sel_out[0] == $past(flags_in[2])))
    else $error("parity condition wrong");
  AST_COND_S: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_RET_COND
      && cond_sel_out[2:1] == 2'h3 |-> cond_met_out == (cond_sel_out[0] == $past(flags_in[7])))
    else $error("sign condition wrong");
  // a condition result outside a return would mislead the cycle logic downstream
  AST_NOT_MET: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && op_class_out != cidec_pkg::CIDEC_CLS_RET_COND |-> !cond_met_out)
    else $error("condition flagged outside a return");
  // a one-operand instruction closes on its second byte
  AST_TWO: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    fetch_valid_in && state.st == cidec_pkg::CIDEC_ST_BYTE2 && state.need == 2'h1
      |=> instr_valid_out && length_out == 2'h2 && operand_lo_out == $past(fetch_data_in))
    else $error("two byte instruction not closed");
  // store through the pair, the stop code excepted
  AST_STORE_M: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && opcode_out[7:3] == 5'h0E && opcode_out != 8'h76
      |-> op_class_out == cidec_pkg::CIDEC_CLS_STORE_M && cycles_out == 5'h07)
    else $error("memory store decode wrong");
  // every completed instruction has a length of at least one byte
  AST_LEN: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out |-> length_out != 2'h0)
    else $error("instruction length zero");
  // jump and call must wait for both address bytes
  AST_JUMP_WAIT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    fetch_valid_in && state.st == cidec_pkg::CIDEC_ST_OPC
      && (fetch_data_in == 8'hC3 || fetch_data_in == 8'hCD)
      |=> !instr_valid_out && state.st == cidec_pkg::CIDEC_ST_BYTE2)
    else $error("jump or call closed early");
  // class and length must agree for the multi-byte groups
  AST_WIDE_LEN: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && (op_class_out == cidec_pkg::CIDEC_CLS_BRANCH
      || op_class_out == cidec_pkg::CIDEC_CLS_DIRECT) |-> length_out == 2'h3)
    else $error("branch length wrong");
  AST_IMM_LEN: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    instr_valid_out && (op_class_out == cidec_pkg::CIDEC_CLS_IMM
      || op_class_out == cidec_pkg::CIDEC_CLS_PORT) |-> length_out == 2'h2)
    else $error("immediate length wrong");
  // scenarios worth seeing at least once
  COV_THREE: cover property (@(posedge clk_sys_in) instr_valid_out && length_out == 2'h3);
  COV_TWO: cover property (@(posedge clk_sys_in) instr_valid_out && length_out == 2'h2);
  COV_RET: cover property (@(posedge clk_sys_in) instr_valid_out && cond_met_out);
  COV_STOP: cover property (@(posedge clk_sys_in)
    instr_valid_out && op_class_out == cidec_pkg::CIDEC_CLS_STOP);
  COV_CARRY: cover property (@(posedge clk_sys_in) instr_valid_out && alu_carry_in_out);

endmodule : cidec_decoder

// File: test/cidec_prog_mem.sv
/*
  program memory model that feeds the instruction decoder one byte per clock, or every other clock when slow_in is high.
  assumes bytes are queued by the bench and taken on any edge where valid and ready are high.
*/
`timescale 1ns/1ps
module cidec_prog_mem (
  input wire logic clk_sys_in,
  input wire logic ready_in,
  input wire logic slow_in,
  output logic [7:0] data_out,
  output logic valid_out
);
  logic [7:0] prog [$];
  int rd = 0;
  logic took;
  initial begin
    data_out = 8'h00;
    valid_out = 1'h0;
  end
  // queue a program byte at the next free address
  task load_byte(input logic [7:0] b);
    prog.push_back(b);
  endtask : load_byte
  ////////////////////////////////////////////////////////////////////////////////
  // present bytes at ascending addresses; an idle bus carries a changing pattern
  always @(posedge clk_sys_in) begin
    took = valid_out & ready_in;
    #1;
    if (took) begin
      rd = rd + 1;
    end
    if (rd < prog.size() && !(took && slow_in)) begin
      valid_out = 1'h1;
      data_out = prog[rd];
    end else begin
      valid_out = 1'h0;
      data_out = ~data_out; // released bus must not look like the last byte
    end
  end
endmodule : cidec_prog_mem

// File: test/tb_cpu_instruction_decode.sv
/*
  self-checking bench for the instruction decoder: table of opcodes, then reset cases.
  assumes the program memory model and the design's assertions sit beside the decoder.
*/
`timescale 1ns/1ps
module tb_cpu_instruction_decode;
  typedef struct packed {
    logic [7:0] op; logic [7:0] lo; logic [7:0] hi; logic [7:0] flg;
    logic [1:0] len; logic [3:0] cls; logic [4:0] cyc; logic met;
  } cidec_row_t;
  logic clk_sys_in = 1'h0;
  logic srst_in = 1'h1;
  logic [7:0] flags_in = 8'h00;
  logic slow = 1'h0;
  logic [7:0] fetch_data;
  logic fetch_valid, fetch_ready, instr_valid_out, alu_carry_in_out, cond_met_out;
  logic [7:0] opcode_out, operand_lo_out, operand_hi_out;
  logic [1:0] length_out, pair_sel_out;
  cidec_pkg::cidec_cls_t op_class_out;
  logic [2:0] dest_out, src_out, alu_sel_out, cond_sel_out;
  logic [15:0] restart_addr_out;
  logic [4:0] cycles_out;
  int fail_count = 0;
  int tests_run = 0;
  // op, byte2, byte3, flags, length, class code, cycles, condition met
  cidec_row_t rows [30] = '{
  '{8'h01,8'h34,8'h12,8'h00,2'h3,4'h7,5'h0A,1'h0}, '{8'h41,8'h00,8'h00,8'h00,2'h1,4'h1,5'h05,1'h0},
  '{8'hC3,8'h00,8'h10,8'h00,2'h3,4'hB,5'h0A,1'h0}, '{8'h31,8'hCD,8'hAB,8'h00,2'h3,4'h7,5'h0A,1'h0},
  '{8'h70,8'h00,8'h00,8'h00,2'h1,4'h2,5'h07,1'h0}, '{8'h76,8'h00,8'h00,8'h00,2'h1,4'h4,5'h07,1'h0},
  '{8'h46,8'h00,8'h00,8'h00,2'h1,4'h3,5'h07,1'h0}, '{8'h80,8'h00,8'h00,8'h01,2'h1,4'h5,5'h04,1'h0},
  '{8'h88,8'h00,8'h00,8'h01,2'h1,4'h5,5'h04,1'h0}, '{8'h8E,8'h00,8'h00,8'h00,2'h1,4'h5,5'h07,1'h0},
  '{8'hC0,8'h00,8'h00,8'h00,2'h1,4'h6,5'h0B,1'h1}, '{8'hC8,8'h00,8'h00,8'h00,2'h1,4'h6,5'h05,1'h0},
  '{8'hE0,8'h00,8'h00,8'h00,2'h1,4'h6,5'h0B,1'h1}, '{8'hE8,8'h00,8'h00,8'h00,2'h1,4'h6,5'h05,1'h0},
  '{8'hF0,8'h00,8'h00,8'h00,2'h1,4'h6,5'h0B,1'h1}, '{8'hF8,8'h00,8'h00,8'h80,2'h1,4'h6,5'h0B,1'h1},
  '{8'hD8,8'h00,8'h00,8'h01,2'h1,4'h6,5'h0B,1'h1}, '{8'hFF,8'h00,8'h00,8'h00,2'h1,4'h8,5'h0B,1'h0},
  '{8'h06,8'h5A,8'h00,8'h00,2'h2,4'h9,5'h07,1'h0}, '{8'hD3,8'h7E,8'h00,8'h00,2'h2,4'hA,5'h0A,1'h0},
  '{8'h3A,8'h00,8'h20,8'h00,2'h3,4'hC,5'h0D,1'h0}, '{8'h21,8'hFF,8'h80,8'h00,2'h3,4'h7,5'h0A,1'h0},
  '{8'h11,8'h01,8'hFE,8'h00,2'h3,4'h7,5'h0A,1'h0}, '{8'hC6,8'h5A,8'h00,8'h00,2'h2,4'h9,5'h07,1'h0},
  '{8'h36,8'hA5,8'h00,8'h00,2'h2,4'h9,5'h0A,1'h0}, '{8'hDB,8'h10,8'h00,8'h00,2'h2,4'hA,5'h0A,1'h0},
  '{8'hCD,8'h00,8'h20,8'h00,2'h3,4'hB,5'h0A,1'h0}, '{8'hC2,8'h34,8'h12,8'h00,2'h3,4'hB,5'h0A,1'h0},
  '{8'h32,8'h78,8'h56,8'h00,2'h3,4'hC,5'h0D,1'h0}, '{8'hD0,8'h00,8'h00,8'h01,2'h1,4'h6,5'h05,1'h0}
  };

  cidec_decoder dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .fetch_data_in(fetch_data),
    .fetch_valid_in(fetch_valid), .flags_in(flags_in), .fetch_ready_out(fetch_ready),
    .instr_valid_out(instr_valid_out), .opcode_out(opcode_out), .operand_lo_out(operand_lo_out),
    .operand_hi_out(operand_hi_out), .length_out(length_out), .op_class_out(op_class_out),
    .dest_out(dest_out), .src_out(src_out), .alu_sel_out(alu_sel_out),
    .alu_carry_in_out(alu_carry_in_out), .cond_sel_out(cond_sel_out),
    .cond_met_out(cond_met_out), .pair_sel_out(pair_sel_out),
    .restart_addr_out(restart_addr_out), .cycles_out(cycles_out));
  cidec_prog_mem mem (.clk_sys_in(clk_sys_in), .ready_in(fetch_ready), .slow_in(slow),
    .data_out(fetch_data), .valid_out(fetch_valid));

  // free-running system clock
  always #50 clk_sys_in = ~clk_sys_in;
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // print counts and verdict, then end the run
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // queue one instruction and its flags
  task load_row(input cidec_row_t r, input logic gaps);
    @(posedge clk_sys_in);
    #1;
    flags_in = r.flg;
    slow = gaps;
    #1;
    mem.load_byte(r.op);
    if (r.len > 2'h1) mem.load_byte(r.lo);
    if (r.len > 2'h2) mem.load_byte(r.hi);
  endtask : load_row
  // wait a bounded time for the completion pulse
  task wait_done;
    int n;
    n = 0;
    @(posedge clk_sys_in);
    #2;
    while (instr_valid_out !== 1'h1 && n < 20) begin
      @(posedge clk_sys_in);
      #2;
      n++;
    end
    if (instr_valid_out !== 1'h1) begin
      chk(16'h0000, 16'h0001);
      report_and_stop();
    end
  endtask : wait_done
  // all decode outputs of one completed instruction; cond_sel_out is checked only for a return
  task check_row(input cidec_row_t r);
    chk(16'(opcode_out), 16'(r.op));
    chk(16'(operand_lo_out), r.len > 2'h1 ? 16'(r.lo) : 16'h0000);
    chk(16'(operand_hi_out), r.len > 2'h2 ? 16'(r.hi) : 16'h0000);
    chk(16'(length_out), 16'(r.len));
    chk(16'(op_class_out), 16'(r.cls));
    chk(16'(cycles_out), 16'(r.cyc));
    chk(16'(dest_out), 16'(r.op[5:3]));
    chk(16'(src_out), 16'(r.op[2:0]));
    chk(16'(alu_sel_out), 16'(r.op[5:3]));
    chk(16'(pair_sel_out), 16'(r.op[5:4]));
    chk(16'(alu_carry_in_out), 16'(r.cls == 4'h5 && r.op[5:3] == 3'h1 && r.flg[0]));
    chk(16'(cond_met_out), 16'(r.met));
    chk(restart_addr_out, r.cls == 4'h8 ? 16'(r.op[5:3]) * 16'h0008 : 16'h0000);
    if (r.cls == 4'h6) chk(16'(cond_sel_out), 16'(r.op[5:3]));
  endtask : check_row
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, table, back-to-back, reset mid-instruction
  initial begin
    repeat (3) @(posedge clk_sys_in);
    #1;
    srst_in = 1'h0;
    #1;
    chk(16'(fetch_ready), 16'h0001);
    chk(16'(instr_valid_out), 16'h0000);
    chk(16'(op_class_out), 16'h0000);
    chk(16'(cycles_out), 16'h0000);
    for (int i = 0; i < 30; i++) begin
      load_row(rows[i], 1'(i % 2));
      wait_done();
      check_row(rows[i]);
    end
    // three instructions with no gap between them
    for (int i = 0; i < 3; i++) load_row(rows[i], 1'h0);
    for (int i = 0; i < 3; i++) begin
      wait_done();
      check_row(rows[i]);
    end
    // reset after an opcode alone, then a fresh single-byte instruction
    load_row(rows[0], 1'h0);
    mem.prog.pop_back();
    mem.prog.pop_back();
    repeat (2) @(posedge clk_sys_in);
    #1;
    srst_in = 1'h1;
    @(posedge clk_sys_in);
    #1;
    srst_in = 1'h0;
    chk(16'(opcode_out), 16'h0000);
    chk(16'(instr_valid_out), 16'h0000);
    load_row(rows[1], 1'h0);
    wait_done();
    check_row(rows[1]);
    report_and_stop();
  end
endmodule : tb_cpu_instruction_decode
